// >>> src/sram_ctrl_pkg.sv
// Purpose: Constants for the 8K x 8 asynchronous static RAM controller
// Assumes: core_clk at 25 MHz, slowest speed grade timing
// Notes: Times in ns, cycle counts derived from the clock period
package sram_ctrl_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int INDEX_W = 13;
  localparam int DATA_W = 8;
  // Slowest grade figures
  localparam int ADDR_ACCESS_NS = 120;
  localparam int DRIVE_ACCESS_NS = 50;
  localparam int STROBE_PULSE_NS = 70;
  localparam int DATA_SETUP_NS = 40;
  localparam int FLOAT_NS = 40;
  // Least times round up
  localparam int ACCESS_CYC = (ADDR_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_CYC = (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_READ  = 5'h02,
    ST_WRITE = 5'h04,
    ST_HOLD  = 5'h08,
    ST_GAP   = 5'h10
  } ctrl_state_t;
endpackage : sram_ctrl_pkg

// >>> src/sram_wait_counter.sv
// Purpose: Down counter that times one bus phase
// Assumes: load and count never needed together beyond load priority
// Notes: done is high while the count is zero
`timescale 1ns/1ns
module sram_wait_counter #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic load,
  input wire logic [W-1:0] value,
  // Status
  output logic done
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= value;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign done = (cnt_q == '0);
endmodule : sram_wait_counter

// >>> src/sram_host_ctrl.sv
// Purpose: Master that reads and writes an 8K x 8 asynchronous static RAM
// Assumes: One request at a time; data pins sampled on core_clk
// Notes: Writes are strobe-terminated with output drive held high
// Summary of operation
// RL1: Both selects active address one word
// RL2: Either select inactive deselects, outputs float
// RL3: Output drive high floats device outputs
// RL4: Read needs strobe high, selects, drive low
// RL5: Stable selection gives data after access time
// RL6: Old data held briefly after index change
// RL7: Select access delay when index already stable
// RL8: Select access independent of deselect time
// RL9: Device drives only when selected and enabled
// RL10: Write starts at last activating edge
// RL11: Drive-low write briefly drives, then floats
// RL12: Master keeps output drive high writing
// RL13: Device stores data, floats during write
// RL14: Index set before write, held past end; here set on the same edge the strobe falls
// RL15: Data setup and hold around strobe rise
// RL16: Select-ended write timed on select edge
// RL17: Drive low at strobe rise returns data
// RL18: Drive high at strobe rise stays floating
// RL19: Never enable outputs while driving write data
// RL20: Array contents undefined, never reset
`timescale 1ns/1ns
module sram_host_ctrl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // User request
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [sram_ctrl_pkg::INDEX_W-1:0] reqIndex,
  input wire logic [sram_ctrl_pkg::DATA_W-1:0] reqData,
  output logic reqReady,
  // User answer
  output logic rspValid,
  output logic [sram_ctrl_pkg::DATA_W-1:0] rspData,
  // Memory pins
  output logic [sram_ctrl_pkg::INDEX_W-1:0] wordIndex,
  output logic selectLowActive_n,
  output logic selectHighActive,
  output logic writeStrobe_n,
  output logic outputDrive_n,
  input wire logic [sram_ctrl_pkg::DATA_W-1:0] dataLinesIn,
  output logic [sram_ctrl_pkg::DATA_W-1:0] dataLinesOut,
  output logic dataLinesOe
);
  //////////////////////////////////////////////////////////////////////////
  sram_ctrl_pkg::ctrl_state_t state_q;
  logic [sram_ctrl_pkg::CNT_W-1:0] waitValue;
  logic waitLoad;
  logic waitDone;
  logic isWrite_q;

  sram_wait_counter #(
    .W(sram_ctrl_pkg::CNT_W)
  ) u_wait (
    .clk(core_clk),
    .rst(sys_rst),
    .load(waitLoad),
    .value(waitValue),
    .done(waitDone)
  );

  // Strobe and float loads hold one less since the load edge itself counts; the read load holds the full ACCESS_CYC
  always_comb begin
    waitLoad = 1'b0;
    waitValue = '0;
    case (state_q)
      sram_ctrl_pkg::ST_IDLE: begin
        if (reqValid) begin
          waitLoad = 1'b1;
          if (reqWrite) begin
            waitValue = sram_ctrl_pkg::CNT_W'(sram_ctrl_pkg::STROBE_CYC - 1);
          end else begin
            waitValue = sram_ctrl_pkg::CNT_W'(sram_ctrl_pkg::ACCESS_CYC);
          end
        end
      end
      sram_ctrl_pkg::ST_WRITE: begin
        if (waitDone) begin
          waitLoad = 1'b1;
          waitValue = '0;
        end
      end
      sram_ctrl_pkg::ST_READ,
      sram_ctrl_pkg::ST_HOLD: begin
        if (waitDone) begin
          waitLoad = 1'b1;
          waitValue = sram_ctrl_pkg::CNT_W'(sram_ctrl_pkg::FLOAT_CYC - 1);
        end
      end
      default: begin
        waitLoad = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= sram_ctrl_pkg::ST_IDLE;
      isWrite_q <= 1'b0;
    end else begin
      case (state_q)
        sram_ctrl_pkg::ST_IDLE: begin
          if (reqValid) begin
            isWrite_q <= reqWrite;
            state_q <= reqWrite ? sram_ctrl_pkg::ST_WRITE : sram_ctrl_pkg::ST_READ;
          end
        end
        sram_ctrl_pkg::ST_READ: begin
          if (waitDone) begin
            state_q <= sram_ctrl_pkg::ST_GAP;
          end
        end
        sram_ctrl_pkg::ST_WRITE: begin
          if (waitDone) begin
            state_q <= sram_ctrl_pkg::ST_HOLD;
          end
        end
        sram_ctrl_pkg::ST_HOLD: begin
          if (waitDone) begin
            state_q <= sram_ctrl_pkg::ST_GAP;
          end
        end
        sram_ctrl_pkg::ST_GAP: begin
          if (waitDone) begin
            state_q <= sram_ctrl_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= sram_ctrl_pkg::ST_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Index and write data; set on the same edge the selects go active, held until after the last
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wordIndex <= '0;
      dataLinesOut <= '0;
    end else if (state_q == sram_ctrl_pkg::ST_IDLE && reqValid) begin
      wordIndex <= reqIndex; // RL14
      dataLinesOut <= reqData; // RL15
    end
  end

  // Selects: both active for the whole access, dropped in the gap
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      selectLowActive_n <= 1'b1; // RL2
      selectHighActive <= 1'b0;
    end else if (state_q == sram_ctrl_pkg::ST_IDLE && reqValid) begin
      selectLowActive_n <= 1'b0; // RL1
      selectHighActive <= 1'b1;
    end else if ((state_q == sram_ctrl_pkg::ST_READ || state_q == sram_ctrl_pkg::ST_HOLD)
                 && waitDone) begin
      selectLowActive_n <= 1'b1; // RL2
      selectHighActive <= 1'b0;
    end
  end

  // Strobe falls with the selects so the write starts there; it rises
  // while selects stay active, ending the write on the strobe edge
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      writeStrobe_n <= 1'b1;
    end else if (state_q == sram_ctrl_pkg::ST_IDLE && reqValid && reqWrite) begin
      writeStrobe_n <= 1'b0; // RL10
    end else if (state_q == sram_ctrl_pkg::ST_WRITE && waitDone) begin
      writeStrobe_n <= 1'b1; // RL15
    end
  end

  // Output drive low only for reads; high through every write
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      outputDrive_n <= 1'b1; // RL3
    end else if (state_q == sram_ctrl_pkg::ST_IDLE && reqValid && !reqWrite) begin
      outputDrive_n <= 1'b0; // RL4
    end else if (state_q == sram_ctrl_pkg::ST_READ && waitDone) begin
      outputDrive_n <= 1'b1; // RL12
    end
  end

  // Bus drive only in write and hold, never with output drive low
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dataLinesOe <= 1'b0;
    end else if (state_q == sram_ctrl_pkg::ST_IDLE && reqValid && reqWrite) begin
      dataLinesOe <= 1'b1; // RL19
    end else if (state_q == sram_ctrl_pkg::ST_HOLD && waitDone) begin
      dataLinesOe <= 1'b0; // RL16
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Answer: sample once the address access time has passed
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rspValid <= 1'b0;
      rspData <= '0;
    end else begin
      rspValid <= 1'b0;
      if (state_q == sram_ctrl_pkg::ST_READ && waitDone) begin
        rspValid <= 1'b1; // RL5
        rspData <= dataLinesIn; // RL7
      end else if (state_q == sram_ctrl_pkg::ST_HOLD && waitDone && isWrite_q) begin
        rspValid <= 1'b1;
      end
    end
  end

  // Ready only in idle after the deselect gap has floated the bus
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reqReady <= 1'b0;
    end else if (state_q == sram_ctrl_pkg::ST_IDLE && reqValid) begin
      reqReady <= 1'b0;
    end else if (state_q == sram_ctrl_pkg::ST_IDLE ||
                 (state_q == sram_ctrl_pkg::ST_GAP && waitDone)) begin
      reqReady <= 1'b1;
    end else begin
      reqReady <= 1'b0;
    end
  end
endmodule : sram_host_ctrl

// >>> test/sram_host_ctrl_props.sv
// Purpose: Pin and handshake checks for the SRAM controller
// Assumes: One clock domain, core_clk
// Notes: Bound to every controller instance
`timescale 1ns/1ns
module sram_host_ctrl_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Handshake
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic reqReady,
  input wire logic rspValid,
  // Memory pins
  input wire logic [sram_ctrl_pkg::INDEX_W-1:0] wordIndex,
  input wire logic selectLowActive_n,
  input wire logic selectHighActive,
  input wire logic writeStrobe_n,
  input wire logic outputDrive_n,
  input wire logic [sram_ctrl_pkg::DATA_W-1:0] dataLinesOut,
  input wire logic dataLinesOe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_wr_float; !writeStrobe_n |-> outputDrive_n; endproperty
  a_wr_float: assert property (p_wr_float) else $error("drive low in write");
  property p_no_fight; dataLinesOe |-> outputDrive_n; endproperty
  a_no_fight: assert property (p_no_fight) else $error("both sides drive");
  property p_wr_sel; !writeStrobe_n |-> !selectLowActive_n && selectHighActive; endproperty
  a_wr_sel: assert property (p_wr_sel) else $error("strobe while deselected");
  property p_wr_hold;
    $rose(writeStrobe_n) |-> $stable(wordIndex) && $stable(dataLinesOut) ##1 $stable(wordIndex);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("index or data moved");
  property p_pulse; $fell(writeStrobe_n) |-> !writeStrobe_n [*2] ##1 writeStrobe_n; endproperty
  a_pulse: assert property (p_pulse) else $error("strobe width wrong");
  property p_rd_cyc;
    reqReady && reqValid && !reqWrite
      |=> (!outputDrive_n && writeStrobe_n) [*4] ##1 (outputDrive_n && rspValid);
  endproperty
  a_rd_cyc: assert property (p_rd_cyc) else $error("read cycle shape");
  property p_wr_rsp; reqReady && reqValid && reqWrite |-> ##4 rspValid ##1 !rspValid; endproperty
  a_wr_rsp: assert property (p_wr_rsp) else $error("write answer late");
  property p_idle; reqReady |-> selectLowActive_n && !selectHighActive && !dataLinesOe; endproperty
  a_idle: assert property (p_idle) else $error("bus not released");
endmodule : sram_host_ctrl_props
bind sram_host_ctrl sram_host_ctrl_props u_sram_host_ctrl_props (.core_clk(core_clk),
  .sys_rst(sys_rst), .reqValid(reqValid), .reqWrite(reqWrite), .reqReady(reqReady),
  .rspValid(rspValid), .wordIndex(wordIndex), .selectLowActive_n(selectLowActive_n),
  .selectHighActive(selectHighActive), .writeStrobe_n(writeStrobe_n),
  .outputDrive_n(outputDrive_n), .dataLinesOut(dataLinesOut), .dataLinesOe(dataLinesOe));

// >>> test/sram_model.sv
// Purpose: Behavioural 8K x 8 static RAM on the controller pins
// Assumes: Write ended by strobe rise only
// Notes: Released bus shows inverted last value, never a held one
`timescale 1ns/1ns
module sram_model (
  // Pins
  input wire logic [12:0] wordIndex,
  input wire logic selectLowActive_n,
  input wire logic selectHighActive,
  input wire logic writeStrobe_n,
  input wire logic outputDrive_n,
  input wire logic [7:0] hostOut,
  input wire logic hostOe,
  output logic [7:0] busLevel
);
  logic [7:0] mem [8192];
  logic sel, devDrive, okQ = 1'b0;
  logic [7:0] lastQ = 8'h00;
  assign sel = !selectLowActive_n && selectHighActive;
  assign devDrive = sel && !outputDrive_n && writeStrobe_n;
  // Data only valid one access time after index or enable moves
  always @(wordIndex or devDrive) begin
    // Both scheduled; a later move does not cancel the pending update of an earlier one
    okQ <= 1'b0;
    okQ <= #(sram_ctrl_pkg::ADDR_ACCESS_NS) devDrive;
  end
  always @(posedge writeStrobe_n) if (sel) mem[wordIndex] <= busLevel;
  always @* begin
    if (hostOe) lastQ = hostOut;
    else if (devDrive && okQ) lastQ = mem[wordIndex];
  end
  assign busLevel = hostOe ? hostOut : (devDrive && okQ) ? mem[wordIndex] : ~lastQ;
endmodule : sram_model

// >>> test/sram_host_ctrl_tb.sv
// Purpose: Self-checking bench for the SRAM controller
// Assumes: Behavioural RAM on the pins
// Notes: Read data checked against a reference array
`timescale 1ns/1ns
module sram_host_ctrl_tb;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reqValid = 1'b0;
  logic reqWrite = 1'b0;
  logic [12:0] reqIndex = 13'h0000;
  logic [7:0] reqData = 8'h00;
  logic reqReady, rspValid, selL_n, selH, strobe_n, drive_n, oe;
  logic [7:0] rspData, busLevel, hostOut;
  logic [12:0] wordIndex;
  logic [8:0] e;
  logic [7:0] refMem [logic [12:0]];
  logic [8:0] expQ [$];
  logic [12:0] idxList [$];
  int error_cnt = 0;
  int cmp_count = 0;
  int seed = 66151;
  always #20 core_clk = ~core_clk;
  sram_host_ctrl u_sram_host_ctrl (.core_clk(core_clk), .sys_rst(sys_rst),
    .reqValid(reqValid), .reqWrite(reqWrite), .reqIndex(reqIndex), .reqData(reqData),
    .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData), .wordIndex(wordIndex),
    .selectLowActive_n(selL_n), .selectHighActive(selH), .writeStrobe_n(strobe_n),
    .outputDrive_n(drive_n), .dataLinesIn(busLevel), .dataLinesOut(hostOut), .dataLinesOe(oe));
  sram_model u_sram_model (.wordIndex(wordIndex), .selectLowActive_n(selL_n),
    .selectHighActive(selH), .writeStrobe_n(strobe_n), .outputDrive_n(drive_n),
    .hostOut(hostOut), .hostOe(oe), .busLevel(busLevel));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask : chk8
  task automatic wrap_up();
    $display("Compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  // Request held until taken; notes the answer at the take edge
  task automatic op(input logic w, input logic [12:0] i, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    reqValid <= 1'b1;
    reqWrite <= w;
    reqIndex <= i;
    reqData <= d;
    do begin @(posedge core_clk); n++; end while (reqReady !== 1'b1 && n < 20);
    reqValid <= 1'b0;
    if (n >= 20) begin
      error_cnt++;
      $display("ERROR %0t request never taken", $time);
    end
    if (w) refMem[i] = d;
    expQ.push_back({w, refMem[i]});
  endtask : op
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) if (rspValid === 1'b1) begin
    if (expQ.size() == 0) chk8(8'hee, 8'h00);
    else begin
      e = expQ.pop_front();
      if (!e[8]) chk8(rspData, e[7:0]);
    end
  end
  // Run needs under two hundred cycles; this allows 2500, over ten times that
  initial begin
    #100000;
    error_cnt++;
    $display("ERROR %0t watchdog expired", $time);
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    idxList = '{13'h0000, 13'h1fff};
    repeat (8) idxList.push_back(13'($random(seed)));
    foreach (idxList[k]) op(1'b1, idxList[k], 8'($random(seed)));
    foreach (idxList[k]) op(1'b0, idxList[k], 8'h00);
    // Overwrite, then two back-to-back reads of the top word
    op(1'b1, 13'h1fff, 8'h5a);
    op(1'b0, 13'h1fff, 8'h00);
    op(1'b0, 13'h1fff, 8'h00);
    repeat (8) @(posedge core_clk);
    // Array must survive a controller reset
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    op(1'b0, 13'h0000, 8'h00);
    repeat (8) @(posedge core_clk);
    chk8(8'(expQ.size()), 8'h00);
    wrap_up();
  end
endmodule : sram_host_ctrl_tb
